// ---- hw/drt_timer.sv ----
// Purpose: Two 8-bit reload down counters with interrupts and waveform pins.
// Assumes: oscillator_input is synchronous to pclk; APB slave, no wait states.
// Notes: Count sources are taps of a prescaler advanced by oscillator edges.
// Contract
// - Four prescaled oscillator sources per timer
// - Write loads counter and reload latch together
// - Read returns counter contents, counting undisturbed
// - Stop bit zero counts, one holds
// - Decrement by one per source rising edge
// - Stop bit sampled while source high
// - Edge after wrap value flags underflow, reloads
// - Underflow sets timer interrupt request bit
// - Waveform mode drives level latch at underflow
// - Pin level undefined before first underflow
// - Read latch captured on source falling edge
// - Waveform mode takes pin from port function
// - Level latch zero low, one high
// - Select field bits 7:6 picks divider
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module drt_timer
   import drt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic oscillator_input,
   input wire logic port1_bit2_data,
   input wire logic port1_bit2_dir,
   input wire logic port1_bit3_data,
   input wire logic port1_bit3_dir,
   output logic first_wave_output,
   output logic second_wave_output,
   output logic port1_bit2_pin_o,
   output logic port1_bit2_pin_oe,
   output logic port1_bit3_pin_o,
   output logic port1_bit3_pin_oe,
   output logic irq
);

   // ==========================================================
   // Helper functions
   function automatic logic pick_src(input logic [1:0] css, input logic [PRESC_W-1:0] p);
      logic s;
      s = 1'b0;
      case (css)
         CSS_DIV8: s = p[TAP_DIV8];
         CSS_DIV64: s = p[TAP_DIV64];
         CSS_DIV128: s = p[TAP_DIV128];
         default: s = p[TAP_DIV256];
      endcase
      return s;
   endfunction : pick_src

   function automatic logic is_addr(input logic [31:0] a, input logic [7:0] ofs);
      return (a[31:8] == 24'h000000) && (a[7:0] == ofs);
   endfunction : is_addr

   // ==========================================================
   // State
   logic osc_q, next_osc_q;
   logic [PRESC_W-1:0] presc, next_presc;
   logic [TMR_W-1:0] cnt [NUM_TMR];
   logic [TMR_W-1:0] next_cnt [NUM_TMR];
   logic [TMR_W-1:0] rld [NUM_TMR];
   logic [TMR_W-1:0] next_rld [NUM_TMR];
   logic [TMR_W-1:0] rdl [NUM_TMR];
   logic [TMR_W-1:0] next_rdl [NUM_TMR];
   logic [TMR_W-1:0] mode [NUM_TMR];
   logic [TMR_W-1:0] next_mode [NUM_TMR];
   logic [NUM_TMR-1:0] src_q, next_src_q;
   logic [NUM_TMR-1:0] stop_eff, next_stop_eff;
   logic [NUM_TMR-1:0] wave, next_wave;
   logic [NUM_TMR-1:0] sts, next_sts;
   logic [NUM_TMR-1:0] ien, next_ien;
   logic [31:0] next_prdata;
   logic [NUM_TMR-1:0] src, uf, cnt_wr;
   logic [NUM_TMR-1:0] clr_bits;
   logic wr_acc, setup, mapped;

   // ==========================================================
   // Bus decode
   assign pready = 1'b1;
   assign wr_acc = psel & penable & pwrite;
   assign setup = psel & ~penable;

   always_comb begin
      mapped = 1'b0;
      if (is_addr(paddr, OFS_CNT1)) begin
         mapped = 1'b1;
      end else if (is_addr(paddr, OFS_CNT2)) begin
         mapped = 1'b1;
      end else if (is_addr(paddr, OFS_MODE1)) begin
         mapped = 1'b1;
      end else if (is_addr(paddr, OFS_MODE2)) begin
         mapped = 1'b1;
      end else if (is_addr(paddr, OFS_STAT)) begin
         mapped = 1'b1;
      end else if (is_addr(paddr, OFS_CLR)) begin
         mapped = 1'b1;
      end else if (is_addr(paddr, OFS_IEN)) begin
         mapped = 1'b1;
      end
   end

   assign pslverr = psel & penable & ~mapped;

   // ==========================================================
   // Read data, registered in the setup cycle
   always_comb begin
      next_prdata = prdata;
      if (setup) begin
         next_prdata = 32'h00000000;
         if (is_addr(paddr, OFS_CNT1)) begin
            next_prdata[TMR_W-1:0] = rdl[0];
         end else if (is_addr(paddr, OFS_CNT2)) begin
            next_prdata[TMR_W-1:0] = rdl[1];
         end else if (is_addr(paddr, OFS_MODE1)) begin
            next_prdata[TMR_W-1:0] = mode[0];
         end else if (is_addr(paddr, OFS_MODE2)) begin
            next_prdata[TMR_W-1:0] = mode[1];
         end else if (is_addr(paddr, OFS_STAT)) begin
            next_prdata[NUM_TMR-1:0] = sts;
         end else if (is_addr(paddr, OFS_IEN)) begin
            next_prdata[NUM_TMR-1:0] = ien;
         end
      end
   end

   // ==========================================================
   // Prescaler advanced by oscillator rising edges
   always_comb begin
      next_osc_q = oscillator_input;
      next_presc = presc;
      if (oscillator_input && !osc_q) begin
         next_presc = presc + 8'h01;
      end
   end

   // ==========================================================
   // Timer cores
   always_comb begin
      cnt_wr[0] = wr_acc & is_addr(paddr, OFS_CNT1);
      cnt_wr[1] = wr_acc & is_addr(paddr, OFS_CNT2);
      clr_bits = '0;
      if (wr_acc && is_addr(paddr, OFS_CLR)) begin
         clr_bits = pwdata[NUM_TMR-1:0];
      end
      next_ien = ien;
      if (wr_acc && is_addr(paddr, OFS_IEN)) begin
         next_ien = pwdata[NUM_TMR-1:0];
      end
      next_src_q = src_q;
      next_stop_eff = stop_eff;
      next_wave = wave;
      src = '0;
      uf = '0;
      for (int i = 0; i < NUM_TMR; i++) begin
         next_cnt[i] = cnt[i];
         next_rld[i] = rld[i];
         next_rdl[i] = rdl[i];
         next_mode[i] = mode[i];
         src[i] = pick_src(mode[i][MODE_CSS_HI:MODE_CSS_LO], presc);
         next_src_q[i] = src[i];
         // The stop bit reaches the counter only while its source is high.
         // A stop written while the source is low still lets the next rising
         // edge count, so software waits one source period after stopping
         // before it relies on a frozen count or a quiet status bit.
         // Reads return the read latch, which may lag the counter by one count.
         if (src[i]) begin
            next_stop_eff[i] = mode[i][MODE_STOP];
         end
         if (src[i] && !src_q[i] && !stop_eff[i]) begin
            if (cnt[i] == CNT_WRAP) begin
               uf[i] = 1'b1;
               next_cnt[i] = rld[i] - 8'h01;
            end else begin
               next_cnt[i] = cnt[i] - 8'h01;
            end
         end
         if (!src[i] && src_q[i]) begin
            next_rdl[i] = cnt[i];
         end
         if (cnt_wr[i]) begin
            next_cnt[i] = pwdata[TMR_W-1:0];
            next_rld[i] = pwdata[TMR_W-1:0];
            next_rdl[i] = pwdata[TMR_W-1:0];
         end
         if (uf[i] && mode[i][MODE_WAVE]) begin
            next_wave[i] = mode[i][MODE_LVL];
         end
      end
      if (wr_acc && is_addr(paddr, OFS_MODE1)) begin
         next_mode[0] = pwdata[TMR_W-1:0] & MODE_MASK;
      end
      if (wr_acc && is_addr(paddr, OFS_MODE2)) begin
         next_mode[1] = pwdata[TMR_W-1:0] & MODE_MASK;
      end
      next_sts = (sts & ~clr_bits) | uf;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_q <= 1'b0;
         presc <= '0;
         src_q <= '0;
         stop_eff <= '0;
         wave <= '0;
         sts <= FLAGS_RST;
         ien <= FLAGS_RST;
         prdata <= 32'h00000000;
         for (int i = 0; i < NUM_TMR; i++) begin
            cnt[i] <= CNT_RST;
            rld[i] <= RLD_RST;
            rdl[i] <= CNT_RST;
            mode[i] <= MODE_RST;
         end
      end else begin
         osc_q <= next_osc_q;
         presc <= next_presc;
         src_q <= next_src_q;
         stop_eff <= next_stop_eff;
         wave <= next_wave;
         sts <= next_sts;
         ien <= next_ien;
         prdata <= next_prdata;
         for (int i = 0; i < NUM_TMR; i++) begin
            cnt[i] <= next_cnt[i];
            rld[i] <= next_rld[i];
            rdl[i] <= next_rdl[i];
            mode[i] <= next_mode[i];
         end
      end
   end

   // ==========================================================
   // Outputs and shared pins
   assign irq = |(sts & ien);
   assign first_wave_output = wave[0];
   assign second_wave_output = wave[1];
   assign port1_bit2_pin_o = mode[0][MODE_WAVE] ? wave[0] : port1_bit2_data;
   assign port1_bit2_pin_oe = mode[0][MODE_WAVE] | port1_bit2_dir;
   assign port1_bit3_pin_o = mode[1][MODE_WAVE] ? wave[1] : port1_bit3_data;
   assign port1_bit3_pin_oe = mode[1][MODE_WAVE] | port1_bit3_dir;

endmodule : drt_timer

// ---- inc/drt_pkg.sv ----
// Purpose: Shared constants for the dual reload timer with waveform output.
// Assumes: APB word addressing, 8-bit timers, data in the low byte.
// Notes: All offsets are byte addresses.
package drt_pkg;
   // ==========================================================
   // Sizes
   localparam int TMR_W = 8;
   localparam int NUM_TMR = 2;
   localparam int PRESC_W = 8;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_CNT1 = 8'h00;
   localparam logic [7:0] OFS_CNT2 = 8'h04;
   localparam logic [7:0] OFS_MODE1 = 8'h08;
   localparam logic [7:0] OFS_MODE2 = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_CLR = 8'h14;
   localparam logic [7:0] OFS_IEN = 8'h18;
   // ==========================================================
   // Mode register fields
   localparam int MODE_STOP = 2;
   localparam int MODE_WAVE = 3;
   localparam int MODE_LVL = 4;
   localparam int MODE_CSS_LO = 6;
   localparam int MODE_CSS_HI = 7;
   localparam logic [7:0] MODE_MASK = 8'hDC;
   localparam logic [7:0] MODE_RST = 8'h00;
   // ==========================================================
   // Count source selection codes and prescaler taps
   localparam logic [1:0] CSS_DIV8 = 2'h0;
   localparam logic [1:0] CSS_DIV64 = 2'h1;
   localparam logic [1:0] CSS_DIV128 = 2'h2;
   localparam logic [1:0] CSS_DIV256 = 2'h3;
   localparam int TAP_DIV8 = 2;
   localparam int TAP_DIV64 = 5;
   localparam int TAP_DIV128 = 6;
   localparam int TAP_DIV256 = 7;
   // ==========================================================
   // Counter values
   localparam logic [7:0] CNT_WRAP = 8'hFF;
   localparam logic [7:0] CNT_RST = 8'hFF;
   localparam logic [7:0] RLD_RST = 8'hFF;
   localparam logic [1:0] FLAGS_RST = 2'h0;
endpackage : drt_pkg

// ---- tb/drt_timer_props.sv ----
// Purpose: Concurrent checks on the dual reload timer ports.
// Assumes: One pclk domain, presetn active low.
// Notes: Bound to every drt_timer instance.
`timescale 1ns/1ps
module drt_timer_props
   import drt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic port1_bit2_data,
   input wire logic first_wave_output,
   input wire logic second_wave_output,
   input wire logic port1_bit2_pin_o,
   input wire logic port1_bit2_pin_oe,
   input wire logic irq
);
   // ==========
   // Helpers
   logic bad;
   assign bad = (paddr[31:8] != 24'h0) || !(paddr[7:0] inside {OFS_CNT1, OFS_CNT2,
      OFS_MODE1, OFS_MODE2, OFS_STAT, OFS_CLR, OFS_IEN});
   default clocking dcb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========
   // Properties
   a_slverr_map: assert property (pslverr == (psel && penable && bad))
      else $error("pslverr does not match the address map");
   a_unmapped_zero: assert property (psel && penable && !pwrite && bad |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
   a_rdata_upper: assert property (prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_rdata_stands: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data changed outside setup");
   a_pin_mux: assert property (port1_bit2_pin_o != port1_bit2_data |->
      port1_bit2_pin_oe && port1_bit2_pin_o == first_wave_output)
      else $error("pin drive neither port nor wave");
   a_wave1_hold: assert property ($changed(first_wave_output) |=>
      $stable(first_wave_output)[*8])
      else $error("first wave changed twice too soon");
   a_wave2_hold: assert property ($changed(second_wave_output) |=>
      $stable(second_wave_output)[*8])
      else $error("second wave changed twice too soon");
   a_irq_masked: assert property (psel && penable && pwrite &&
      paddr == {24'h0, OFS_IEN} && pwdata[1:0] == 2'h0 |=> !irq)
      else $error("irq high with all enables off");
endmodule : drt_timer_props
bind drt_timer drt_timer_props drt_timer_props_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pslverr(pslverr), .port1_bit2_data(port1_bit2_data),
   .first_wave_output(first_wave_output), .second_wave_output(second_wave_output),
   .port1_bit2_pin_o(port1_bit2_pin_o), .port1_bit2_pin_oe(port1_bit2_pin_oe), .irq(irq));

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the dual reload timer.
// Assumes: oscillator_input toggles every pclk, so the prescaler steps every 2 pclk.
// Notes: A count source period is twice its divider in pclk cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module testbench
   import drt_pkg::*;
;
   // ==========
   // Signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic osc = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pd = 4'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, err;
   logic [1:0] w, po, poe;
   logic [7:0] n, v;
   int miscompares = 0;
   int n_compared = 0;
   int seed = 72136;
   int cyc = 0;
   int t, t0;
   initial forever #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      osc <= ~osc;
   end
   drt_timer drt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .oscillator_input(osc), .port1_bit2_data(pd[0]),
      .port1_bit2_dir(pd[1]), .port1_bit3_data(pd[2]), .port1_bit3_dir(pd[3]),
      .first_wave_output(w[0]), .second_wave_output(w[1]), .port1_bit2_pin_o(po[0]),
      .port1_bit2_pin_oe(poe[0]), .port1_bit3_pin_o(po[1]), .port1_bit3_pin_oe(poe[1]),
      .irq(irq));
   // ==========
   // Tasks
   task finish_test;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         miscompares++;
         finish_test();
      end
   endtask : apb
   task wait_irq;
      int i;
      for (i = 0; i < 9000; i++) begin
         @(posedge pclk);
         #1;
         if (irq === 1'b1) break;
      end
      if (i == 9000) begin
         miscompares++;
         finish_test();
      end
   endtask : wait_irq
   function automatic int per(int k, int nv);
      return (nv + 1) * 2 * ((k == 0) ? 8 : (k == 1) ? 64 : (k == 2) ? 128 : 256);
   endfunction : per
   // ==========
   // Sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_MODE1, 0);
      `CHK("mode1 reset", 32'h0, rd)
      apb(0, OFS_STAT, 0);
      `CHK("stat reset", 32'h0, rd)
      apb(0, 32'h1C, 0);
      `CHK("unmapped err", 1'b1, err)
      apb(1, OFS_MODE2, 32'hFF);
      apb(0, OFS_MODE2, 0);
      `CHK("mode2 mask", {24'h0, MODE_MASK}, rd)
      apb(1, OFS_MODE1, 32'h04);
      repeat (600) @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         apb(1, OFS_CNT1, {24'h0, v});
         repeat (600) @(posedge pclk);
         apb(0, OFS_CNT1, 0);
         `CHK("held count", {24'h0, v}, rd)
      end
      for (int k = 0; k < 4; k++) begin
         t = k % 2;
         n = (k == 0) ? 8'hFF : (k == 2) ? 8'h00 : 8'($random(seed) & 3);
         pd <= 4'($random(seed));
         apb(1, t ? OFS_MODE1 : OFS_MODE2, 32'h04);
         apb(1, t ? OFS_MODE2 : OFS_MODE1, 32'h04);
         repeat (600) @(posedge pclk);
         apb(1, t ? OFS_CNT2 : OFS_CNT1, {24'h0, n});
         apb(1, OFS_CLR, 32'h3);
         apb(1, OFS_IEN, 32'(1 << t));
         apb(1, t ? OFS_MODE2 : OFS_MODE1, {24'h0, 2'(k), 1'b0, ~k[1], 4'h8});
         wait_irq();
         t0 = cyc;
         `CHK("wave", ~k[1], w[t])
         `CHK("wave pin", {1'b1, ~k[1]}, {poe[t], po[t]})
         `CHK("port pin", {pd[3 - 2 * t], pd[2 - 2 * t]}, {poe[1 - t], po[1 - t]})
         apb(0, OFS_STAT, 0);
         `CHK("stat", 32'(1 << t), rd)
         apb(1, OFS_CLR, 32'(1 << t));
         apb(0, t ? OFS_CNT2 : OFS_CNT1, 0);
         wait_irq();
         `CHK("interval", per(k, n), cyc - t0)
      end
      apb(1, OFS_IEN, 32'h0);
      repeat (3000) @(posedge pclk);
      #1;
      `CHK("masked irq", 1'b0, irq)
      apb(1, OFS_MODE2, 32'h04);
      repeat (600) @(posedge pclk);
      apb(0, OFS_STAT, 0);
      `CHK("sticky stat", 32'h2, rd)
      apb(1, OFS_CLR, 32'h2);
      apb(0, OFS_STAT, 0);
      `CHK("cleared stat", 32'h0, rd)
      finish_test();
   end
endmodule : testbench
